/* File: include/rab_pkg.sv */
// Purpose: Shared constants and carriers for the register attribute bank.
// Assumes: Byte-wide registers with 16-bit addresses.
// Notes: The serial engine and the storage controller share one clock.
package rab_pkg;

    ////////////////////////////////////////////////////////////////////////
    localparam logic [15:0] RAB_ADDR_CONFIG = 16'h0000;
    localparam logic [15:0] RAB_ADDR_READSEL = 16'h0004;
    localparam logic [15:0] RAB_ADDR_UPDATE = 16'h0005;
    localparam logic [15:0] RAB_ADDR_BUF_SER = 16'h0100;
    localparam logic [15:0] RAB_ADDR_BUF_SYS = 16'h0101;
    localparam logic [15:0] RAB_ADDR_STATUS = 16'h0102;

    ////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] RAB_RST_CONFIG = 8'h10;
    localparam logic [7:0] RAB_RST_BUF_SER = 8'h00;
    localparam logic [7:0] RAB_RST_BUF_SYS = 8'h00;
    localparam int RAB_CFG_SOFT_RST_BIT = 5;
    localparam int RAB_READSEL_BIT = 0;
    localparam int RAB_UPDATE_BIT = 0;
    localparam int RAB_STAT_UPD_BIT = 0;
    localparam int RAB_STAT_PEND_BIT = 1;

    ////////////////////////////////////////////////////////////////////////
    localparam int RAB_SYS_DIV = 32;

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] data;
    } rab_req_type;

    typedef struct packed {
        logic busy;
        logic load;
        logic store;
        logic [15:0] addr;
        logic [7:0] data;
    } rab_ee_type;

endpackage

/* File: hdl/rab_update_div.sv */
// Purpose: Holds a buffered update until the next system clock / 32 tick.
// Assumes: req_in is a single-cycle pulse on the same clock.
// Notes: fire_out pulses for one cycle when the held update is released.
module rab_update_div
    import rab_pkg::*;
#(
    parameter int DIV_RATIO = RAB_SYS_DIV
)
(
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic req_in,
    output logic fire_out,
    output logic pending_out
);

    localparam int CW = $clog2(DIV_RATIO);
    localparam logic [CW-1:0] LAST = CW'(DIV_RATIO - 1);

    // A ratio below two leaves no counter bits to wrap.
    if (DIV_RATIO < 2)
    begin : g_ratio_check
        $error("DIV_RATIO must be at least 2.");
    end

    logic [CW-1:0] cnt_q, cnt_d;
    logic pend_q, pend_d;
    logic fire_q, fire_d;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        cnt_d = (cnt_q == LAST) ? '0 : cnt_q + CW'(1);
        fire_d = 1'b0;
        pend_d = pend_q;
        if (pend_q && cnt_q == LAST)
        begin
            fire_d = 1'b1;
            pend_d = 1'b0;
        end
        if (req_in)
            pend_d = 1'b1;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            cnt_q <= '0;
            pend_q <= 1'b0;
            fire_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            pend_q <= pend_d;
            fire_q <= fire_d;
        end
    end

    assign fire_out = fire_q;
    assign pending_out = pend_q;

endmodule

/* File: hdl/rab_bank.sv */
// Purpose: Byte register bank with live, buffered, read-only, autoclear
//          and storage-excluded attribute classes.
// Assumes: Requests come from the serial engine on the same clock.
// Notes: Read data answers one cycle after a read request.
//
// Contract
// - Writes to unmapped addresses are ignored and change nothing.
// - Autoclear bits clear themselves once their action is done.
// - Excluded registers are neither stored to nor loaded from storage.
// - Live registers take effect at the write, no update needed.
// - Read-only registers read back but ignore writes.
// - Serial-class buffers copy to active on the serial-side update.
// - System-class buffers copy to active on the system clock / 32 tick.
// - Writing one to update bit 0 transfers all buffered values.
module rab_bank
    import rab_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire rab_req_type host_req_in,
    input wire rab_ee_type ee_req_in,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    output logic [7:0] ee_data_out,
    output logic ee_ok_out,
    output logic [7:0] config_out,
    output logic [7:0] active_ser_out,
    output logic [7:0] active_sys_out
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic excluded(input logic [15:0] a);
        excluded = (a == RAB_ADDR_CONFIG) || (a == RAB_ADDR_UPDATE)
            || (a == RAB_ADDR_STATUS) || (a == RAB_ADDR_READSEL);
    endfunction

    function automatic logic mapped(input logic [15:0] a);
        mapped = excluded(a) || (a == RAB_ADDR_BUF_SER)
            || (a == RAB_ADDR_BUF_SYS);
    endfunction

    logic [7:0] cfg_q, cfg_d;
    logic sel_q, sel_d;
    logic upd_q, upd_d;
    logic [7:0] bser_q, bser_d, aser_q, aser_d;
    logic [7:0] bsys_q, bsys_d, asys_q, asys_d;
    logic [7:0] rdat_q, rdat_d;
    logic rval_q, rval_d;
    logic [7:0] edat_q, edat_d;
    logic eok_q, eok_d;
    logic fire, pending;
    logic [7:0] status;
    logic host_wr;

    rab_update_div #(.DIV_RATIO(RAB_SYS_DIV)) u_div (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .req_in(upd_q),
        .fire_out(fire),
        .pending_out(pending)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        status = 8'h00;
        status[RAB_STAT_UPD_BIT] = upd_q;
        status[RAB_STAT_PEND_BIT] = pending;
        // The storage controller owns the bank while it runs.
        host_wr = host_req_in.wr && !ee_req_in.busy;
        cfg_d = cfg_q;
        sel_d = sel_q;
        upd_d = upd_q;
        bser_d = bser_q;
        aser_d = aser_q;
        bsys_d = bsys_q;
        asys_d = asys_q;
        if (upd_q)
        begin
            aser_d = bser_q;
            upd_d = 1'b0;
        end
        if (fire)
            asys_d = bsys_q;
        if (cfg_q[RAB_CFG_SOFT_RST_BIT])
        begin
            cfg_d[RAB_CFG_SOFT_RST_BIT] = 1'b0;
            sel_d = 1'b0;
            bser_d = RAB_RST_BUF_SER;
            bsys_d = RAB_RST_BUF_SYS;
        end
        if (ee_req_in.load && !excluded(ee_req_in.addr))
        begin
            unique case (ee_req_in.addr)
                RAB_ADDR_BUF_SER: bser_d = ee_req_in.data;
                RAB_ADDR_BUF_SYS: bsys_d = ee_req_in.data;
                default: ;
            endcase
        end
        if (host_wr && mapped(host_req_in.addr))
        begin
            unique case (host_req_in.addr)
                RAB_ADDR_CONFIG: cfg_d = host_req_in.data;
                RAB_ADDR_READSEL: sel_d = host_req_in.data[RAB_READSEL_BIT];
                RAB_ADDR_UPDATE:
                    upd_d = upd_d | host_req_in.data[RAB_UPDATE_BIT];
                RAB_ADDR_BUF_SER: bser_d = host_req_in.data;
                RAB_ADDR_BUF_SYS: bsys_d = host_req_in.data;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        rval_d = host_req_in.rd;
        rdat_d = 8'h00;
        if (host_req_in.rd)
        begin
            unique case (host_req_in.addr)
                RAB_ADDR_CONFIG: rdat_d = cfg_q;
                RAB_ADDR_READSEL: rdat_d = {7'h00, sel_q};
                RAB_ADDR_UPDATE: rdat_d = {7'h00, upd_q};
                RAB_ADDR_BUF_SER: rdat_d = sel_q ? bser_q : aser_q;
                RAB_ADDR_BUF_SYS: rdat_d = sel_q ? bsys_q : asys_q;
                RAB_ADDR_STATUS: rdat_d = status;
                default: rdat_d = 8'h00;
            endcase
        end
        eok_d = 1'b0;
        edat_d = 8'h00;
        if (ee_req_in.store && mapped(ee_req_in.addr)
            && !excluded(ee_req_in.addr))
        begin
            eok_d = 1'b1;
            edat_d = (ee_req_in.addr == RAB_ADDR_BUF_SER) ? bser_q : bsys_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            cfg_q <= RAB_RST_CONFIG;
            sel_q <= 1'b0;
            upd_q <= 1'b0;
            bser_q <= RAB_RST_BUF_SER;
            aser_q <= RAB_RST_BUF_SER;
            bsys_q <= RAB_RST_BUF_SYS;
            asys_q <= RAB_RST_BUF_SYS;
            rdat_q <= 8'h00;
            rval_q <= 1'b0;
            edat_q <= 8'h00;
            eok_q <= 1'b0;
        end
        else
        begin
            cfg_q <= cfg_d;
            sel_q <= sel_d;
            upd_q <= upd_d;
            bser_q <= bser_d;
            aser_q <= aser_d;
            bsys_q <= bsys_d;
            asys_q <= asys_d;
            rdat_q <= rdat_d;
            rval_q <= rval_d;
            edat_q <= edat_d;
            eok_q <= eok_d;
        end
    end

    assign rd_data_out = rdat_q;
    assign rd_valid_out = rval_q;
    assign ee_data_out = edat_q;
    assign ee_ok_out = eok_q;
    assign config_out = cfg_q;
    assign active_ser_out = aser_q;
    assign active_sys_out = asys_q;

    ////////////////////////////////////////////////////////////////////////
    logic quiet_ee;
    assign quiet_ee = !ee_req_in.load && !cfg_q[RAB_CFG_SOFT_RST_BIT];

    a_unmapped_write: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in)
        host_req_in.wr && !mapped(host_req_in.addr) && quiet_ee && !upd_q
        |=> $stable(cfg_q) && $stable(bser_q) && $stable(bsys_q)
            && $stable(sel_q))
        else $error("Unmapped write changed a register.");

    a_update_clear: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in)
        upd_q && !(host_wr && host_req_in.addr == RAB_ADDR_UPDATE)
        |=> !upd_q)
        else $error("Update bit did not clear itself.");

    a_ee_excluded: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in)
        ee_req_in.store && excluded(ee_req_in.addr) |=> !ee_ok_out)
        else $error("Excluded register was stored.");

    a_live_write: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in)
        host_wr && host_req_in.addr == RAB_ADDR_CONFIG
        |=> config_out == $past(host_req_in.data))
        else $error("Live write did not take effect at once.");

    a_status_read: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in)
        host_req_in.rd && host_req_in.addr == RAB_ADDR_STATUS
        |=> rd_valid_out && rd_data_out[RAB_STAT_PEND_BIT] == $past(pending))
        else $error("Read-only register read wrong.");

    a_ser_transfer: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in)
        upd_q |=> active_ser_out == $past(bser_q))
        else $error("Serial-class transfer missed.");

    a_sys_transfer: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in)
        fire |=> active_sys_out == $past(bsys_q))
        else $error("System-class transfer missed.");

    a_update_start: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in)
        host_wr && host_req_in.addr == RAB_ADDR_UPDATE
        && host_req_in.data[RAB_UPDATE_BIT]
        |=> upd_q ##1 pending ##[1:32] fire)
        else $error("Update write did not run both transfers.");

    c_update: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        upd_q ##[1:40] fire);
    c_soft_reset: cover property (@(posedge sys_clk_in)
        disable iff (sys_rst_in) cfg_q[RAB_CFG_SOFT_RST_BIT]);
    c_ee_load: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        ee_req_in.load && !excluded(ee_req_in.addr));

endmodule

/* File: verif/rab_host_model.sv */
// Purpose: Host on the serial control port of the register bank.
// Assumes: One request at a time; read data comes one cycle later.
// Notes: Tasks drive at the rising edge and then release the bus.
module rab_host_model
    import rab_pkg::*;
(
    input wire logic clk_in,
    input wire logic [7:0] rd_data_in,
    input wire logic rd_valid_in,
    output rab_req_type req_out
);
    timeunit 1ns;
    timeprecision 100ps;

    initial req_out = '0;

    // Callers pass whole bytes with unused bits at their defaults.
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_in);
        req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(posedge clk_in);
        req_out <= '0;
    endtask

    task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_in);
        req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
        @(posedge clk_in);
        req_out <= '0;
        #1;
        d = rd_valid_in ? rd_data_in : 8'hXX;
    endtask
endmodule

/* File: verif/test_rab_bank.sv */
// Purpose: Self-checking bench for the register attribute bank.
// Assumes: Host model drives requests; bench drives storage requests.
// Notes: Timeout cuts the run short after 5000 cycles.
module test_rab_bank
    import rab_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic sys_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    rab_req_type host_req;
    rab_ee_type ee_req = '0;
    logic [7:0] rd_data, ee_data, cfg, act_ser, act_sys, v;
    logic rd_valid, ee_ok;
    int bad_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int n;

    rab_bank rab_bank_inst (
        .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .host_req_in(host_req), .ee_req_in(ee_req),
        .rd_data_out(rd_data), .rd_valid_out(rd_valid),
        .ee_data_out(ee_data), .ee_ok_out(ee_ok), .config_out(cfg),
        .active_ser_out(act_ser), .active_sys_out(act_sys)
    );

    rab_host_model rab_host_model_inst (
        .clk_in(sys_clk_in), .rd_data_in(rd_data),
        .rd_valid_in(rd_valid), .req_out(host_req)
    );

    initial
    begin
        forever #25 sys_clk_in = ~sys_clk_in;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("tests %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic ee_op(input logic ld, st, input logic [15:0] a,
                         input logic [7:0] d);
        @(posedge sys_clk_in);
        ee_req <= '{busy: 1'b0, load: ld, store: st, addr: a, data: d};
        @(posedge sys_clk_in);
        ee_req <= '0;
        #1;
    endtask

    always @(posedge sys_clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            bad_count++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        rab_host_model_inst.rd_reg(RAB_ADDR_CONFIG, v);
        chk("config_reset", RAB_RST_CONFIG, v);
        chk("active_ser_reset", RAB_RST_BUF_SER, act_ser);
        rab_host_model_inst.wr_reg(RAB_ADDR_CONFIG, 8'h90);
        #1;
        chk("config_live", 8'h90, cfg);
        rab_host_model_inst.wr_reg(RAB_ADDR_CONFIG, RAB_RST_CONFIG);
        rab_host_model_inst.wr_reg(RAB_ADDR_STATUS, 8'h03);
        rab_host_model_inst.rd_reg(RAB_ADDR_STATUS, v);
        chk("status_ro", 8'h00, v);
        rab_host_model_inst.wr_reg(16'h0200, 8'h55);
        rab_host_model_inst.rd_reg(16'h0200, v);
        chk("unmapped_rd", 8'h00, v);
        chk("unmapped_cfg", RAB_RST_CONFIG, cfg);
        rab_host_model_inst.wr_reg(RAB_ADDR_BUF_SER, 8'hAA);
        rab_host_model_inst.wr_reg(RAB_ADDR_BUF_SYS, 8'h55);
        chk("ser_held", 8'h00, act_ser);
        chk("sys_held", 8'h00, act_sys);
        rab_host_model_inst.wr_reg(RAB_ADDR_UPDATE, 8'h01);
        repeat (2) @(posedge sys_clk_in);
        #1;
        chk("ser_update", 8'hAA, act_ser);
        rab_host_model_inst.rd_reg(RAB_ADDR_UPDATE, v);
        chk("update_clear", 8'h00, v);
        n = 4;
        while (act_sys !== 8'h55 && n < 40)
        begin
            @(posedge sys_clk_in);
            #1;
            n++;
        end
        chk("sys_delay_ok", 8'h01, {7'h00, n <= 34});
        ee_op(1'b0, 1'b1, RAB_ADDR_BUF_SYS, 8'h00);
        chk("store_ok", 8'h01, {7'h00, ee_ok});
        chk("store_data", 8'h55, ee_data);
        ee_op(1'b0, 1'b1, RAB_ADDR_CONFIG, 8'h00);
        chk("store_excl", 8'h00, {7'h00, ee_ok});
        ee_op(1'b1, 1'b0, RAB_ADDR_CONFIG, 8'h00);
        chk("load_excl", RAB_RST_CONFIG, cfg);
        ee_op(1'b1, 1'b0, RAB_ADDR_BUF_SYS, 8'h77);
        ee_op(1'b0, 1'b1, RAB_ADDR_BUF_SYS, 8'h00);
        chk("load_store", 8'h77, ee_data);
        rab_host_model_inst.wr_reg(RAB_ADDR_READSEL, 8'h01);
        rab_host_model_inst.rd_reg(RAB_ADDR_BUF_SYS, v);
        chk("sel_buffered", 8'h77, v);
        rab_host_model_inst.wr_reg(RAB_ADDR_READSEL, 8'h00);
        rab_host_model_inst.rd_reg(RAB_ADDR_BUF_SYS, v);
        chk("sel_active", 8'h55, v);
        // A host write while the storage controller is busy is dropped.
        @(posedge sys_clk_in);
        ee_req.busy <= 1'b1;
        rab_host_model_inst.wr_reg(RAB_ADDR_CONFIG, 8'h90);
        ee_req.busy <= 1'b0;
        #1;
        chk("busy_block", RAB_RST_CONFIG, cfg);
        rab_host_model_inst.wr_reg(RAB_ADDR_CONFIG, 8'h30);
        rab_host_model_inst.rd_reg(RAB_ADDR_CONFIG, v);
        chk("soft_rst_clear", RAB_RST_CONFIG, v);
        rab_host_model_inst.wr_reg(RAB_ADDR_READSEL, 8'h01);
        rab_host_model_inst.rd_reg(RAB_ADDR_BUF_SER, v);
        chk("soft_rst_buf", RAB_RST_BUF_SER, v);
        chk("soft_rst_active", 8'hAA, act_ser);
        end_sim();
    end
endmodule
